// ### logic/opv_pkg.sv
`default_nettype none
package opv_pkg;
  // clock rate of the controller
  localparam int CLK_HZ = 10_000_000;
  // pulse timing in microseconds
  localparam int PULSE_LOW_US = 100;
  localparam int PULSE_HIGH_MIN_US = 10;
  localparam int VPP_SETUP_US = 10;
  localparam int VPP_HOLD_US = 10;
  // derived cycle counts (10 MHz: 10 cycles per us)
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int PULSE_LOW_CYC = PULSE_LOW_US * CYC_PER_US;
  localparam int PULSE_HIGH_CYC = PULSE_HIGH_MIN_US * CYC_PER_US;
  localparam int VPP_SETUP_CYC = VPP_SETUP_US * CYC_PER_US;
  localparam int VPP_HOLD_CYC = VPP_HOLD_US * CYC_PER_US;
  // setup and hold: 48 oscillator periods at the slowest 4 MHz is 12 us
  localparam int SETUP_US = 12;
  localparam int SETUP_CYC = SETUP_US * CYC_PER_US;
  // verify settle: 48 oscillator periods at the slowest 4 MHz
  localparam int READ_WAIT_CYC = SETUP_CYC;
  localparam int PULSE_COUNT = 5;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h0001;
  localparam logic [2:0] PULSE_ONE = 3'h1;
  // encryption table last address
  localparam logic [15:0] ENC_LAST_ADDR = 16'h001F;
  // signature locations
  localparam logic [15:0] SIG_MAKER_ADDR = 16'h0030;
  localparam logic [15:0] SIG_PART_ADDR = 16'h0031;
  // port 0 bit positions for readout fields
  localparam int LOCK1_BIT = 7;
  localparam int LOCK2_BIT = 6;
  localparam int LOCK3_BIT = 3;
  localparam int CLKOPT_BIT = 4;
  // user commands
  typedef enum logic [3:0] {
    OPV_CMD_PGM_CODE = 4'h0,
    OPV_CMD_PGM_ENC = 4'h1,
    OPV_CMD_PGM_LOCK1 = 4'h2,
    OPV_CMD_PGM_LOCK2 = 4'h3,
    OPV_CMD_PGM_LOCK3 = 4'h4,
    OPV_CMD_PGM_6CLK = 4'h5,
    OPV_CMD_VERIFY = 4'h6,
    OPV_CMD_SIG = 4'h7,
    OPV_CMD_VFY_LOCK = 4'h8,
    OPV_CMD_VFY_CLK = 4'h9
  } opv_cmd_t;
  // select pin set: p27,p26,p37,p36,p33
  typedef struct packed {
    logic p27;
    logic p26;
    logic p37;
    logic p36;
    logic p33;
  } opv_sel_t;
  localparam opv_sel_t SEL_IDLE = 5'h00;
endpackage : opv_pkg
`default_nettype wire

// ### logic/opv_tmr_if.sv
`default_nettype none
// timer request and done between sequencer and timer
interface opv_tmr_if;
  logic load;
  logic [opv_pkg::CNT_W-1:0] count;
  logic done;
  modport ctl(output load, output count, input done);
  modport tmr(input load, input count, output done);
endinterface : opv_tmr_if
`default_nettype wire

// ### logic/opv_timer.sv
`default_nettype none
// down counter; done while idle at zero
module opv_timer (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // timer port
  opv_tmr_if.tmr t
);
  import opv_pkg::*;
  logic [CNT_W-1:0] cnt; // remaining cycles
  //////////////////////////////////////////////////////////////////
  // count down after a load
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (t.load) begin
      cnt <= t.count;
    end else if (cnt != '0) begin
      cnt <= cnt - CNT_ONE;
    end
  end
  // done one cycle early so the load-to-done span equals count
  assign t.done = (cnt == CNT_ONE) || (cnt == '0);
endmodule : opv_timer
`default_nettype wire

// ### logic/opv_host.sv
`default_nettype none
// Behaviour
// - keep device oscillator running at 4-6 MHz
// - address on ports 1/2, data port 0
// - code program levels, reset high, strobe low
// - exactly five low programming pulses each
// - pulse low 100us, high at least 10us
// - encryption table at addresses 0 to 1FH
// - lock bit select patterns per bit
// - verify levels, device drives port 0
// - signature reads at 030h/031h, P3.6/P3.7 low
// - lock bits readback on P0.7, P0.6, P0.3
// - 6-clock option program select levels
module opv_host (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // user command port
  input wire logic cmd_valid_in,
  input wire opv_pkg::opv_cmd_t cmd_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  // device oscillator enable
  output logic osc_en_out,
  // device control pins
  output logic dev_reset_out,
  output logic program_store_strobe_out,
  output logic program_pulse_pin_out,
  output logic vpp_high_out,
  output logic ea_level_out,
  // select pins
  output logic p27_out,
  output logic p26_out,
  output logic p37_out,
  output logic p36_out,
  output logic p33_out,
  // address ports
  output logic [7:0] port1_out,
  output logic [7:0] port2_low_out,
  // port 0 two-way, oe low means driving
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic port0_oe_n_out
);
  import opv_pkg::*;

  //////////////////////////////////////////////////////////////////
  // state machine
  // one-hot codes; each step drives its own pin levels
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SETUP = 8'h02,
    ST_VPP_ON = 8'h04,
    ST_PULSE_LO = 8'h08,
    ST_PULSE_HI = 8'h10,
    ST_VPP_OFF = 8'h20,
    ST_READ = 8'h40,
    ST_DONE = 8'h80
  } opv_state_t;

  opv_state_t state; // current step
  opv_state_t next_state; // step after this cycle
  logic is_pgm; // latched command programs
  logic [2:0] pulses; // pulses still to give
  opv_sel_t sel; // select pattern for command
  opv_sel_t next_sel; // pattern decoded from input
  logic next_is_pgm; // decoded programming flag
  logic [CNT_W-1:0] tmr_count; // timer value to load
  logic tmr_load; // timer start strobe
  logic accept; // command taken this cycle

  // one shared down counter paces every step except idle and done; only one interval runs at a time
  opv_tmr_if tif();
  opv_timer u_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .t(tif)
  );
  // timer request from the sequencer
  assign tif.load = tmr_load;
  assign tif.count = tmr_count;
  // a command is taken only from idle; one offered while busy is ignored, not queued
  assign accept = cmd_valid_in && (state == ST_IDLE);

  //////////////////////////////////////////////////////////////////
  // decode select levels for the incoming command
  always_comb begin
    next_sel = SEL_IDLE;
    next_is_pgm = 1'b1;
    // p3.3 is a don't-care outside the 6-clock modes and is driven low there
    case (cmd_in)
      OPV_CMD_PGM_CODE: next_sel = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      OPV_CMD_PGM_ENC: next_sel = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      OPV_CMD_PGM_LOCK1: next_sel = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      OPV_CMD_PGM_LOCK2: next_sel = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      OPV_CMD_PGM_LOCK3: next_sel = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      OPV_CMD_PGM_6CLK: next_sel = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      OPV_CMD_VERIFY: begin
        next_sel = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        next_is_pgm = 1'b0;
      end
      OPV_CMD_SIG: begin
        next_sel = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        next_is_pgm = 1'b0;
      end
      OPV_CMD_VFY_LOCK: begin
        // p2.7 is the enable, held low while reading
        next_sel = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        next_is_pgm = 1'b0;
      end
      OPV_CMD_VFY_CLK: begin
        next_sel = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        next_is_pgm = 1'b0;
      end
      default: begin
        // unused codes leave every select low and never raise vpp
        next_sel = SEL_IDLE;
        next_is_pgm = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////
  // next state and timer loads
  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state)
      // idle: start the settle interval as soon as a command is taken
      ST_IDLE: begin
        if (accept) begin
          next_state = ST_SETUP;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(SETUP_CYC);
        end
      end
      // selects, address and data have settled; programming raises vpp next
      ST_SETUP: begin
        if (tif.done) begin
          tmr_load = 1'b1;
          if (is_pgm) begin
            next_state = ST_VPP_ON;
            tmr_count = CNT_W'(VPP_SETUP_CYC);
          end else begin
            // readout: no vpp, just wait for port 0 to settle
            next_state = ST_READ;
            tmr_count = CNT_W'(READ_WAIT_CYC);
          end
        end
      end
      // vpp setup before the first pulse falls
      ST_VPP_ON: begin
        if (tif.done) begin
          next_state = ST_PULSE_LO;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(PULSE_LOW_CYC);
        end
      end
      // pulse low; the span is the nominal width, well inside the limits
      ST_PULSE_LO: begin
        if (tif.done) begin
          next_state = ST_PULSE_HI;
          tmr_load = 1'b1;
          tmr_count = CNT_W'(PULSE_HIGH_CYC);
        end
      end
      // gap between pulses; after the fifth pulse it counts toward vpp hold
      ST_PULSE_HI: begin
        if (tif.done) begin
          tmr_load = 1'b1;
          if (pulses == PULSE_ONE) begin
            next_state = ST_VPP_OFF;
            tmr_count = CNT_W'(VPP_HOLD_CYC);
          end else begin
            next_state = ST_PULSE_LO;
            tmr_count = CNT_W'(PULSE_LOW_CYC);
          end
        end
      end
      // vpp hold after the last pulse rises, then report
      ST_VPP_OFF: begin
        if (tif.done) begin
          next_state = ST_DONE;
        end
      end
      // port 0 is sampled when this wait runs out
      ST_READ: begin
        if (tif.done) begin
          next_state = ST_DONE;
        end
      end
      // one cycle for the answer, then back to idle
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////
  // state register
  // asynchronous reset puts the sequencer in idle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////
  // latch command, address, data and select pattern
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      is_pgm <= 1'b0;
      sel <= SEL_IDLE;
      port1_out <= '0;
      port2_low_out <= '0;
      port0_out <= '0;
    end else if (accept) begin
      // held for the whole command; the device reads them during every pulse
      is_pgm <= next_is_pgm;
      sel <= next_sel;
      port1_out <= cmd_addr_in[7:0];
      port2_low_out <= cmd_addr_in[15:8];
      port0_out <= cmd_data_in;
    end
  end

  //////////////////////////////////////////////////////////////////
  // pulse counter, five per programming operation
  // a 3-bit count is enough for the fixed train of five
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulses <= '0;
    end else if (accept) begin
      // reload on every take, so a cut train never carries over
      pulses <= 3'(PULSE_COUNT);
    end else if (state == ST_PULSE_HI && tif.done) begin
      pulses <= pulses - PULSE_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////
  // pin drive; select pins change only in setup, one cycle after the take, never under vpp
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_reset_out <= 1'b0;
      program_store_strobe_out <= 1'b1;
      program_pulse_pin_out <= 1'b1;
      vpp_high_out <= 1'b0;
      ea_level_out <= 1'b1;
      osc_en_out <= 1'b0;
      {p27_out, p26_out, p37_out, p36_out, p33_out} <= SEL_IDLE;
      port0_oe_n_out <= 1'b1;
    end else begin
      // oscillator on for the whole session (4-6 MHz source outside)
      osc_en_out <= 1'b1;
      dev_reset_out <= 1'b1;
      program_store_strobe_out <= 1'b0;
      // selects follow the latched pattern one cycle after the take
      {p27_out, p26_out, p37_out, p36_out, p33_out} <= sel;
      // high voltage from vpp setup through hold
      vpp_high_out <= (next_state == ST_VPP_ON) || (next_state == ST_PULSE_LO) ||
                      (next_state == ST_PULSE_HI) || (next_state == ST_VPP_OFF);
      // logic-high level on the external access pin whenever vpp is not applied
      ea_level_out <= 1'b1;
      // pulse pin falls only inside the pulse-low step
      program_pulse_pin_out <= (next_state != ST_PULSE_LO);
      // drive port 0 only for programming; float it for every readout
      port0_oe_n_out <= !(is_pgm && (next_state != ST_IDLE) && (state != ST_IDLE));
    end
  end

  //////////////////////////////////////////////////////////////////
  // handshake and readout capture
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= '0;
    end else begin
      // ready follows the idle state so a take and a busy flag never overlap
      cmd_ready_out <= (next_state == ST_IDLE);
      // one-cycle answer strobe at the end of every command
      rsp_valid_out <= (state == ST_VPP_OFF || state == ST_READ) && tif.done;
      if (state == ST_READ && tif.done) begin
        // raw byte; decoding of encrypted data is left to the user
        rsp_data_out <= port0_in;
      end else if (state == ST_VPP_OFF && tif.done) begin
        // programming answers carry no data
        rsp_data_out <= '0;
      end
    end
  end
endmodule : opv_host
`default_nettype wire

// ### tb/opv_dev_model.sv
`default_nettype none
// behavioural device seen through its programming pins
module opv_dev_model #(
  parameter logic [7:0] MAKER = 8'h00,
  parameter logic [7:0] PART = 8'h00
) (
  // control pins
  input wire logic rst_in,
  input wire logic strobe_in,
  input wire logic pulse_in,
  input wire logic vpp_in,
  input wire opv_pkg::opv_sel_t sel_in,
  // address and port 0
  input wire logic [15:0] addr_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] drv_out,
  output logic drv_en_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import opv_pkg::*;
  logic [7:0] mem [256]; // code array, only low address byte kept
  logic [7:0] enc [32]; // key table, read only through the verify XOR
  logic [2:0] lk; // lock bits, 1 = programmed
  logic six;
  logic enc_on;
  int npl; // pulses seen under high voltage
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (enc[i]) enc[i] = 8'hFF;
    lk = 3'h0;
    six = 1'b0;
    enc_on = 1'b0;
    npl = 0;
  end
  always @(negedge pulse_in) if (vpp_in) npl++;
  //////////////////////////////////////////////////////////////////////
  // burn at high voltage removal, only after a full train of pulses
  always @(negedge vpp_in) begin
    if (npl == PULSE_COUNT && rst_in && !strobe_in) begin
      case ({sel_in.p27, sel_in.p26, sel_in.p37, sel_in.p36})
        4'b1011: if (lk == 3'h0) mem[addr_in[7:0]] = bus_in;
        4'b1010: if (lk == 3'h0) begin
          enc[addr_in[4:0]] = bus_in;
          enc_on = 1'b1;
        end
        4'b1111: lk[0] = 1'b1;
        4'b1100: lk[1] = 1'b1;
        4'b0101: lk[2] = 1'b1;
        4'b0010: if (!sel_in.p33) six = 1'b1;
        default: ;
      endcase
    end
    npl = 0;
  end
  //////////////////////////////////////////////////////////////////////
  // port 0 driven only in a read mode with high voltage off
  always_comb begin
    drv_en_out = rst_in && !strobe_in && !vpp_in && pulse_in && !sel_in.p27;
    drv_out = 8'hFF;
    case ({sel_in.p26, sel_in.p37, sel_in.p36})
      3'b011: begin
        if (lk[2:1] != 2'h0) drv_en_out = 1'b0;
        drv_out = enc_on ? ~(mem[addr_in[7:0]] ^ enc[addr_in[4:0]]) : mem[addr_in[7:0]];
      end
      3'b000: begin
        if (addr_in == SIG_MAKER_ADDR) drv_out = MAKER;
        if (addr_in == SIG_PART_ADDR) drv_out = PART;
      end
      3'b010: drv_out = ~{lk[0], lk[1], 2'h0, lk[2], 3'h0};
      3'b001: drv_out = {3'h7, ~six, 4'hF};
      default: drv_en_out = 1'b0;
    endcase
  end
endmodule // opv_dev_model
`default_nettype wire

// ### tb/opv_host_chk.sv
`default_nettype none
// pin timing watchdog for the programmer controller
module opv_host_chk (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // handshake
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  // device pins
  input wire logic program_pulse_pin_out,
  input wire logic vpp_high_out,
  input wire logic program_store_strobe_out,
  input wire logic dev_reset_out,
  input wire logic port0_oe_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [11:0] low_cnt; // cycles low in current pulse
  logic [11:0] high_cnt; // cycles high under vpp, cleared when vpp off
  logic [2:0] pulse_cnt; // pulses in this vpp window
  logic pulse_q; // pulse pin one edge ago, idle high so reset gives no edge
  logic pulse_fell; // pulse pin fell since the last edge
  assign pulse_fell = pulse_q && !program_pulse_pin_out;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt <= 12'h000;
      high_cnt <= 12'h000;
      pulse_cnt <= 3'h0;
      pulse_q <= 1'b1;
    end else begin
      low_cnt <= program_pulse_pin_out ? 12'h000 : low_cnt + 12'h001;
      high_cnt <= (vpp_high_out && program_pulse_pin_out) ? high_cnt + 12'h001 : 12'h000;
      pulse_cnt <= !vpp_high_out ? 3'h0 : pulse_cnt + {2'h0, pulse_fell};
      pulse_q <= program_pulse_pin_out;
    end
  end
  sequence s_taken;
    cmd_valid_in && cmd_ready_out;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_pulse_under_vpp: assert property (!program_pulse_pin_out |-> vpp_high_out)
    else $error("pulse low without high voltage");
  a_pulse_low_width: assert property ($rose(program_pulse_pin_out) |->
    low_cnt >= 12'd900 && low_cnt <= 12'd1100)
    else $error("pulse width out of range");
  a_pulse_high_gap: assert property ($fell(program_pulse_pin_out) |-> high_cnt >= 12'd100)
    else $error("pulse gap or vpp setup too short");
  a_vpp_hold_time: assert property ($fell(vpp_high_out) |-> high_cnt >= 12'd100)
    else $error("vpp hold too short");
  a_five_pulses: assert property ($fell(vpp_high_out) |-> pulse_cnt == 3'h5)
    else $error("pulse count not five");
  a_prog_levels: assert property (vpp_high_out |->
    !port0_oe_n_out && !program_store_strobe_out && dev_reset_out)
    else $error("programming levels wrong");
  a_idle_quiet: assert property (cmd_ready_out |-> program_pulse_pin_out && !vpp_high_out)
    else $error("pins active while idle");
  a_taken_busy: assert property (s_taken |=> !cmd_ready_out)
    else $error("ready stayed high after take");
  a_rsp_single: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
endmodule // opv_host_chk
bind opv_host opv_host_chk u_chk (.clock_in, .rst_n_in, .cmd_valid_in, .cmd_ready_out,
  .rsp_valid_out, .program_pulse_pin_out, .vpp_high_out, .program_store_strobe_out,
  .dev_reset_out, .port0_oe_n_out);
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
// programmer controller against the behavioural device
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import opv_pkg::*;
  localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
  localparam logic [7:0] PART_ID = 8'hC3; // arbitrary value
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  opv_cmd_t cmd_in = OPV_CMD_VERIFY;
  logic [15:0] cmd_addr_in = 16'h0000;
  logic [7:0] cmd_data_in = 8'h00;
  logic cmd_ready_out, rsp_valid_out, osc_en_out, dev_reset_out, strobe, pulse, vpp, oe_n, dev_en;
  logic [7:0] rsp_data_out, port1, port2, port0_drv, dev_drv;
  logic ea; // level on the external access pin
  wire opv_sel_t sel;
  wire logic [7:0] port0_bus;
  int bad_count = 0;
  int comparisons = 0;
  // pull-ups hold port 0 high when nobody drives it
  assign port0_bus = !oe_n ? port0_drv : dev_en ? dev_drv : 8'hFF;
  always #50 clock_in = ~clock_in;
  opv_host dut (.clock_in, .rst_n_in, .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_data_in,
    .cmd_ready_out, .rsp_valid_out, .rsp_data_out, .osc_en_out, .dev_reset_out,
    .program_store_strobe_out(strobe), .program_pulse_pin_out(pulse), .vpp_high_out(vpp),
    .ea_level_out(ea), .p27_out(sel.p27), .p26_out(sel.p26), .p37_out(sel.p37),
    .p36_out(sel.p36), .p33_out(sel.p33), .port1_out(port1), .port2_low_out(port2),
    .port0_in(port0_bus), .port0_out(port0_drv), .port0_oe_n_out(oe_n));
  opv_dev_model #(.MAKER(MAKER_ID), .PART(PART_ID)) u_dev (.rst_in(dev_reset_out),
    .strobe_in(strobe), .pulse_in(pulse), .vpp_in(vpp), .sel_in(sel),
    .addr_in({port2, port1}), .bus_in(port0_bus), .drv_out(dev_drv), .drv_en_out(dev_en));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one command: hold valid until taken, then wait for the answer
  task automatic run(input opv_cmd_t c, input logic [15:0] a, input logic [7:0] d, e);
    int n;
    n = 0;
    cmd_in <= c;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    cmd_valid_in <= 1'b1;
    do begin @(posedge clock_in); n++; end while (cmd_ready_out !== 1'b1 && n < 9000);
    cmd_valid_in <= 1'b0;
    do begin @(posedge clock_in); n++; end while (rsp_valid_out !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      bad_count++;
      results();
    end else check(rsp_data_out, e);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock_in);
    check({pulse, vpp, oe_n, cmd_ready_out, ea, 3'h0}, 8'hA8);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    check({cmd_ready_out, osc_en_out, dev_reset_out, strobe, ea, 3'h0}, 8'hE8);
    run(OPV_CMD_PGM_CODE, 16'h0005, 8'hA5, 8'h00);
    run(OPV_CMD_VERIFY, 16'h0005, 8'h00, 8'hA5);
    run(OPV_CMD_VERIFY, 16'h0006, 8'h00, 8'hFF);
    run(OPV_CMD_SIG, SIG_MAKER_ADDR, 8'h00, MAKER_ID);
    run(OPV_CMD_SIG, SIG_PART_ADDR, 8'h00, PART_ID);
    run(OPV_CMD_VFY_CLK, 16'h0000, 8'h00, 8'hFF);
    run(OPV_CMD_PGM_6CLK, 16'h0000, 8'h00, 8'h00);
    run(OPV_CMD_VFY_CLK, 16'h0000, 8'h00, 8'hEF);
    run(OPV_CMD_PGM_ENC, 16'h0005, 8'h0F, 8'h00);
    run(OPV_CMD_VERIFY, 16'h0005, 8'h00, 8'h55);
    run(OPV_CMD_VFY_LOCK, 16'h0000, 8'h00, 8'hFF);
    run(OPV_CMD_PGM_LOCK1, 16'h0000, 8'h00, 8'h00);
    run(OPV_CMD_PGM_CODE, 16'h0006, 8'h00, 8'h00);
    run(OPV_CMD_VERIFY, 16'h0006, 8'h00, 8'hFF);
    run(OPV_CMD_VFY_LOCK, 16'h0000, 8'h00, 8'h7F);
    run(OPV_CMD_PGM_LOCK2, 16'h0000, 8'h00, 8'h00);
    run(OPV_CMD_PGM_LOCK3, 16'h0000, 8'h00, 8'h00);
    run(OPV_CMD_VFY_LOCK, 16'h0000, 8'h00, 8'h37);
    run(OPV_CMD_VERIFY, 16'h0005, 8'h00, 8'hFF);
    results();
  end
endmodule // tb_top
`default_nettype wire
